/* File: rtl/serial_eeprom_write_ctrl.sv */
// two-wire eeprom slave: addressing, page latch and write timing
// assumes: pins are asynchronous to mclk and sampled here; the array
// itself sits outside and takes one byte per mem_we pulse
//
// Operation
// - array is 128 pages of 16 bytes
// - serial block type 1011, bits 3..1 zero
// - device byte bits 3..1 give addr 10..8
// - bit 0 one reads, zero writes
// - ack matching device byte, else nack
// - word address byte gives low eight bits
// - serial word address tag 10, rest ignored
// - byte write acked, stop starts programming
// - bus ignored while programming
// - page write one to 16 bytes, same row
// - up to fifteen more bytes, each acked
// - only low four bits increment, wrap
// - nack while programming, ack right after
// - write-protect high protects whole array
// - write-protect sampled at the stop
// - protected write acked, no programming
// - sample on scl rise, drive on fall
// - standby after plain stop or programming
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_write_ctrl #(
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic wp,
    output logic mem_we,
    output logic [eeprom_pkg::ADDR_W-1:0] mem_addr,
    output logic [eeprom_pkg::BYTE_W-1:0] mem_wdata,
    output logic prog_busy,
    output logic standby
);
    localparam logic [eeprom_pkg::PROG_CNT_W-1:0] PROG_LAST =
        eeprom_pkg::PROG_CNT_W'(PROG_CYCLES - 1);

    // ------------------------------------------------------------
    // pin sampling and bus events
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic scl_q;
    logic sda_q;

    // scl, sda and wp all pass two flops
    pin_sync #(.WIDTH(3)) u_sync (
        .clk(mclk),
        .reset_n(reset_n),
        .d({wp, sda_in, scl}),
        .q(pins_s)
    );

    wire scl_s = pins_s[0];
    wire sda_s = pins_s[1];
    wire wp_s = pins_s[2];

    // previous samples for edge finding
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // edges of scl, start and stop with scl held high
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;
    wire start_evt = scl_s && scl_q && sda_q && !sda_s;
    wire stop_evt = scl_s && scl_q && !sda_q && sda_s;

    // ------------------------------------------------------------
    // byte framing
    // ------------------------------------------------------------
    eeprom_pkg::link_state_t state;
    eeprom_pkg::link_state_t next_state;
    logic [3:0] bit_cnt;
    logic ack_phase;
    logic [eeprom_pkg::BYTE_W-1:0] shreg;
    logic [eeprom_pkg::ADDR_W-1:0] addr;
    logic sn_sel;
    logic data_seen;
    logic [eeprom_pkg::PROG_CNT_W-1:0] prog_cnt;

    // bits are taken only in the receiving states
    wire rx_state = (state == eeprom_pkg::ST_DEV) ||
                    (state == eeprom_pkg::ST_WORD) ||
                    (state == eeprom_pkg::ST_DATA);
    wire in_prog = (state == eeprom_pkg::ST_PROG);
    wire bit_rx = rx_state && scl_rise &&
                  (bit_cnt < eeprom_pkg::BITS_PER_BYTE);
    // fall after the eighth bit opens the ack slot
    wire byte_done = rx_state && scl_fall && !ack_phase &&
                     (bit_cnt == eeprom_pkg::BITS_PER_BYTE);
    // fall after the ninth clock closes it
    wire ack_end = scl_fall && ack_phase;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire dev_main = (shreg[7:4] == eeprom_pkg::ID_MAIN);
    wire dev_sn = (shreg[7:4] == eeprom_pkg::ID_SERIAL) &&
                  (shreg[3:1] == eeprom_pkg::SN_HI_BITS);
    wire dev_hit = dev_main || dev_sn;
    wire rd_req = shreg[0];
    wire sn_tag_ok = (shreg[7:6] == eeprom_pkg::SN_WORD_TAG);
    // device byte acked on match, address and data always
    wire give_ack = (state == eeprom_pkg::ST_DEV) ? dev_hit :
                    ((state == eeprom_pkg::ST_WORD) ||
                     (state == eeprom_pkg::ST_DATA));
    // stop after data, unprotected, main array only
    wire prog_go = (state == eeprom_pkg::ST_DATA) && data_seen &&
                   !sn_sel && !wp_s;
    wire prog_last = in_prog && (prog_cnt == PROG_LAST);
    // the first page-size cycles of programming walk the latch
    wire walk = in_prog && (prog_cnt[eeprom_pkg::PROG_CNT_W-1:
                                     eeprom_pkg::OFS_W] == '0);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // programming shuts out start and stop entirely
    always_comb begin
        next_state = state;
        if (in_prog) begin
            if (prog_last) begin
                next_state = eeprom_pkg::ST_IDLE;
            end
        end else if (start_evt) begin
            next_state = eeprom_pkg::ST_DEV;
        end else if (stop_evt) begin
            next_state = prog_go ? eeprom_pkg::ST_PROG :
                                   eeprom_pkg::ST_IDLE;
        end else if (ack_end) begin
            unique case (state)
                eeprom_pkg::ST_DEV: begin
                    next_state = (dev_hit && !rd_req) ?
                        eeprom_pkg::ST_WORD : eeprom_pkg::ST_SKIP;
                end
                eeprom_pkg::ST_WORD: begin
                    next_state = eeprom_pkg::ST_DATA;
                end
                eeprom_pkg::ST_IDLE, eeprom_pkg::ST_DATA,
                eeprom_pkg::ST_SKIP, eeprom_pkg::ST_PROG: begin
                    next_state = state;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state <= eeprom_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // bit count on scl rises; ack slot and sda drive on scl falls
    always_ff @(posedge mclk) begin
        if (!reset_n || start_evt || stop_evt || in_prog) begin
            bit_cnt <= '0;
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            if (bit_rx) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_done) begin
                ack_phase <= 1'b1;
                sda_oe <= give_ack;
            end
            if (ack_end) begin
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
                bit_cnt <= '0;
            end
        end
    end

    // shift in msb first on scl rises
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            shreg <= '0;
        end else if (bit_rx) begin
            shreg <= {shreg[6:0], sda_s};
        end
    end

    // open-drain data only ever pulls low
    always_ff @(posedge mclk) begin
        sda_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // word address and page latch
    // ------------------------------------------------------------
    wire take_dev = byte_done && (state == eeprom_pkg::ST_DEV) &&
                    dev_hit && !rd_req;
    wire take_word = byte_done && (state == eeprom_pkg::ST_WORD);
    wire take_data = byte_done && (state == eeprom_pkg::ST_DATA);

    // pointer update; only the in-page offset counts
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            addr <= '0;
            sn_sel <= 1'b0;
            data_seen <= 1'b0;
        end else if (take_dev) begin
            sn_sel <= dev_sn;
            data_seen <= 1'b0;
            if (dev_main) begin
                addr[10:8] <= shreg[3:1];
            end
        end else if (take_word) begin
            // serial block: low six bits are don't care
            addr[7:0] <= (sn_sel && sn_tag_ok) ? '0 : shreg;
        end else if (take_data) begin
            addr[3:0] <= addr[3:0] + 4'h1;
            data_seen <= 1'b1;
        end
    end

    logic [eeprom_pkg::BYTE_W-1:0] buf_data;
    logic buf_loaded;

    // bytes wait here until stop, then the walk reads them
    page_buffer u_page (
        .clk(mclk),
        .reset_n(reset_n),
        .clear(take_word),
        .wr_en(take_data),
        .wr_idx(addr[3:0]),
        .wr_data(shreg),
        .rd_idx(prog_cnt[eeprom_pkg::OFS_W-1:0]),
        .rd_data(buf_data),
        .rd_loaded(buf_loaded)
    );

    // ------------------------------------------------------------
    // self-timed programming
    // ------------------------------------------------------------
    // runs from the stop until the configured length
    always_ff @(posedge mclk) begin
        if (!reset_n || !in_prog) begin
            prog_cnt <= '0;
        end else begin
            prog_cnt <= prog_cnt + 1'b1;
        end
    end

    // array write port: one pulse per loaded byte of the row
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
        end else begin
            mem_we <= walk && buf_loaded;
            mem_addr <= {addr[10:4], prog_cnt[3:0]};
            mem_wdata <= buf_data;
        end
    end

    // status outputs follow the next state
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prog_busy <= 1'b0;
            standby <= 1'b1;
        end else begin
            prog_busy <= (next_state == eeprom_pkg::ST_PROG);
            standby <= (next_state == eeprom_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_prog_silent: assert property (
        in_prog |-> !sda_oe && !ack_phase)
        else $error("bus answered during programming");

    a_nack_mismatch: assert property (
        byte_done && state == eeprom_pkg::ST_DEV && !dev_hit
        |=> !sda_oe [*2])
        else $error("mismatched device byte acked");

    a_ack_main: assert property (
        byte_done && state == eeprom_pkg::ST_DEV && dev_main
        |=> sda_oe)
        else $error("main array address not acked");

    a_upper_bits: assert property (
        take_dev && dev_main |=> addr[10:8] == $past(shreg[3:1]))
        else $error("upper word address bits not taken");

    a_page_wrap: assert property (
        take_data |=> addr[10:4] == $past(addr[10:4]) &&
        addr[3:0] == $past(addr[3:0]) + 4'h1)
        else $error("pointer left its page");

    a_stop_starts: assert property (
        stop_evt && !in_prog && prog_go
        |=> in_prog && prog_busy)
        else $error("stop after data did not program");

    a_wp_blocks: assert property (
        stop_evt && state == eeprom_pkg::ST_DATA && wp_s
        |=> state == eeprom_pkg::ST_IDLE ##1 standby)
        else $error("protected write started programming");

    a_prog_length: assert property (
        prog_last |=> state == eeprom_pkg::ST_IDLE && !prog_busy)
        else $error("programming did not end on count");

    a_drive_on_fall: assert property (
        $rose(sda_oe) |-> $past(scl_fall))
        else $error("sda driven off an scl fall");

    c_byte_write: cover property (
        take_data ##[1:300] stop_evt && prog_go);
    c_protected: cover property (
        stop_evt && state == eeprom_pkg::ST_DATA && wp_s);
    c_poll_nack: cover property (
        in_prog && start_evt);
    c_wrap: cover property (
        take_data && addr[3:0] == 4'hf);
endmodule : serial_eeprom_write_ctrl
`default_nettype wire

/* File: rtl/eeprom_pkg.sv */
// shared constants and types of the serial eeprom write logic
// assumes: one 100 MHz system clock, bus pins sampled in that domain
package eeprom_pkg;
    // array shape: 128 pages of 16 bytes, 11-bit word address
    localparam int PAGE_COUNT = 128;
    localparam int PAGE_BYTES = 16;
    localparam int ADDR_W = 11;
    localparam int OFS_W = 4;
    localparam int BYTE_W = 8;
    // device address byte fields
    localparam logic [3:0] ID_MAIN = 4'ha;
    localparam logic [3:0] ID_SERIAL = 4'hb;
    localparam logic [2:0] SN_HI_BITS = 3'h0;
    // serial block word address tag in bits 7..6
    localparam logic [1:0] SN_WORD_TAG = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // self-timed programming time and its cycle count
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WR_NS = 1000000;
    localparam int PROG_CYCLES_DEF = T_WR_NS / CLK_PERIOD_NS;
    localparam int PROG_CNT_W = 20;
    // link sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_WORD, ST_DATA, ST_SKIP, ST_PROG
    } link_state_t;
endpackage : eeprom_pkg

/* File: rtl/pin_sync.sv */
// two-flop synchroniser for a group of asynchronous pins
// assumes: inputs are unrelated to clk; only q is read downstream
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta <= '1;
            q <= '1;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pin_sync
`default_nettype wire

/* File: rtl/page_buffer.sv */
// page latch: one byte and one loaded flag per page entry
// assumes: writer and reader on the same clock, clear wins over write
`timescale 1ns/100ps
`default_nettype none
module page_buffer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [eeprom_pkg::OFS_W-1:0] wr_idx,
    input wire logic [eeprom_pkg::BYTE_W-1:0] wr_data,
    input wire logic [eeprom_pkg::OFS_W-1:0] rd_idx,
    output logic [eeprom_pkg::BYTE_W-1:0] rd_data,
    output logic rd_loaded
);
    logic [eeprom_pkg::BYTE_W-1:0] mem [eeprom_pkg::PAGE_BYTES];
    logic [eeprom_pkg::PAGE_BYTES-1:0] loaded;

    // one entry per page byte
    for (genvar i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin : g_ent
        wire hit = wr_en && (wr_idx == eeprom_pkg::OFS_W'(i));
        always_ff @(posedge clk) begin
            if (!reset_n || clear) begin
                loaded[i] <= 1'b0;
                mem[i] <= '0;
            end else if (hit) begin
                loaded[i] <= 1'b1;
                mem[i] <= wr_data;
            end
        end
    end

    // read side for the programming walk
    assign rd_data = mem[rd_idx];
    assign rd_loaded = loaded[rd_idx];
endmodule : page_buffer
`default_nettype wire

/* File: tb/i2c_host_model.sv */
// bus master model: drives scl and its own side of sda
// assumes: sda_line is the wired bus level, high through a pull-up
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
    input wire logic mclk,
    input wire logic sda_line,
    output var logic scl,
    output var logic sda_drv
);
    int stall = 0; // extra low cycles for a slow host
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // start or repeated start: sda falls while scl is high
    task automatic bus_start;
        tick(5);
        sda_drv <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_drv <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask : bus_start
    // one byte msb first, then releases sda for the ack clock
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            tick(2 + stall);
            sda_drv <= b[i]; // changes only while scl low
            tick(3);
            scl <= 1'b1;
            tick(3);
            scl <= 1'b0;
        end
        tick(2 + stall);
        sda_drv <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(2);
        ack = ~sda_line;
        tick(1);
        scl <= 1'b0;
    endtask : send_byte
    // stop: sda rises while scl is high, then the bus idles high
    task automatic bus_stop;
        tick(5);
        sda_drv <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_drv <= 1'b1;
        tick(4);
    endtask : bus_stop
endmodule : i2c_host_model
`default_nettype wire

/* File: tb/serial_eeprom_address_write_logic_tb.sv */
// self-checking bench of the eeprom write control
// assumes: host model on the bus, array writes watched at mem_we
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module serial_eeprom_address_write_logic_tb;
    localparam int PROG = 300;
    logic mclk, reset_n, wp, scl, sda_drv, sda_line, sda_out, sda_oe;
    logic mem_we, prog_busy, standby;
    logic [10:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [18:0] exp_q[$];
    logic [18:0] e;
    int num_errors = 0;
    int n_compared = 0;
    // open-drain bus: low if either party pulls
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
    serial_eeprom_write_ctrl #(.PROG_CYCLES(PROG)) uut (
        .mclk(mclk), .reset_n(reset_n), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .prog_busy(prog_busy), .standby(standby)
    );
    i2c_host_model host (
        .mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // each array write takes the oldest expected note
    always @(posedge mclk) begin
        if (mem_we === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHECK(1'b1, 1'b0)
            end else begin
                e = exp_q.pop_front();
                `CHECK({mem_addr, mem_wdata}, e)
            end
        end
    end
    task automatic print_verdict;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // -----------------------------------------------------------
    // frame tasks: n < 0 address only, n = 0 dummy write
    // -----------------------------------------------------------
    task automatic wr(input logic [7:0] dev, input logic [7:0] word,
                      input int n, input logic ok, input logic prog);
        logic ack;
        logic [7:0] d;
        logic [7:0] pend [16];
        logic [15:0] hit;
        hit = '0;
        host.bus_start();
        host.send_byte(dev, ack);
        `CHECK(ack, ok)
        if (n >= 0) begin
            host.send_byte(word, ack);
            `CHECK(ack, ok)
        end
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            host.send_byte(d, ack);
            `CHECK(ack, ok)
            pend[4'(word + 8'(k))] = d;
            hit[4'(word + 8'(k))] = 1'b1;
        end
        for (int o = 0; o < 16; o++) begin
            if (prog && hit[o]) begin
                exp_q.push_back({dev[3:1], word[7:4], 4'(o), pend[o]});
            end
        end
        host.bus_stop();
    endtask : wr
    // after a stop: busy or not, polled, then ready again
    task automatic after_stop(input logic busy);
        int c;
        c = 0;
        `CHECK(prog_busy, busy)
        `CHECK(standby, ~busy)
        wr(8'ha0, 8'h00, -1, ~busy, 1'b0);
        while (prog_busy !== 1'b0 && c < 2 * PROG) begin
            @(posedge mclk);
            c++;
        end
        `CHECK(c < PROG, 1'b1)
        `CHECK(c > 0, busy)
        `CHECK(standby, 1'b1)
        wr(8'ha0, 8'h00, -1, 1'b1, 1'b0);
    endtask : after_stop
    initial begin
        reset_n = 1'b0;
        wp = 1'b0;
        void'($urandom(14261));
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        wr(8'ha6, 8'h35, 1, 1'b1, 1'b1);
        wp <= 1'b1; // late change must not stop it
        after_stop(1'b1);
        wr(8'hae, 8'h7e, 4, 1'b1, 1'b0);
        after_stop(1'b0);
        wp <= 1'b0;
        wr(8'hae, 8'h7e, 4, 1'b1, 1'b1);
        after_stop(1'b1);
        host.stall = 6;
        wr(8'ha0, 8'h00, 16, 1'b1, 1'b1);
        host.stall = 0;
        after_stop(1'b1);
        wr(8'hb0, 8'h80, 2, 1'b1, 1'b0);
        after_stop(1'b0);
        wr(8'ha2, 8'h10, 0, 1'b1, 1'b0);
        after_stop(1'b0);
        wr(8'h90, 8'h00, -1, 1'b0, 1'b0);
        wr(8'hb2, 8'h00, -1, 1'b0, 1'b0);
        wr(8'hb8, 8'h00, -1, 1'b0, 1'b0);
        wr(8'ha1, 8'h00, -1, 1'b1, 1'b0);
        repeat (20) @(posedge mclk);
        `CHECK(exp_q.size(), 0)
        print_verdict();
    end
    // watchdog well beyond the expected run time
    initial begin
        #400us;
        num_errors++;
        print_verdict();
    end
endmodule : serial_eeprom_address_write_logic_tb
`default_nettype wire
